/* File: rtl/frps_ctrl.sv */
// host-side controller that runs the flash row program sequence
`timescale 1ns/10ps
module frps_ctrl
  import frps_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [15:0] row_addr,
  output logic             byte_req,
  input  wire logic [7:0]  byte_data,
  input  wire logic        byte_last,
  output logic             busy,
  output logic             done,
  output logic             err_not_erased,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic [15:0]      bus_addr,
  output logic [7:0]       bus_wdata,
  input  wire logic [7:0]  bus_rdata,
  input  wire logic [7:0]  cur_data
);
  // assertions below share this clock and reset
  default clocking frps_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  frps_tmr_if tif ();
  frps_timer u_tmr (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  frps_state_e      st_q, st_d;
  logic [ROW_W-1:0] idx_q, idx_d;
  logic [15:0]      row_q, row_d;
  logic             last_q, last_d;
  logic             wr_d, rd_d;
  logic [15:0]      addr_d;
  logic [7:0]       wdata_d;
  logic             done_d, err_d;
  logic [7:0]       prot_q, prot_d;

  // next state and bus command
  always_comb begin
    st_d      = st_q;
    idx_d     = idx_q;
    row_d     = row_q;
    last_d    = last_q;
    prot_d    = prot_q;
    wr_d      = 1'b0;
    rd_d      = 1'b0;
    addr_d    = bus_addr;
    wdata_d   = bus_wdata;
    done_d    = 1'b0;
    err_d     = err_not_erased;
    tif.load  = 1'b0;
    tif.count = '0;
    byte_req  = 1'b0;
    case (st_q) // sequenced in logic, not by code in the array
      FRPS_IDLE: begin
        if (start) begin
          row_d = {row_addr[15:ROW_W], {ROW_W{1'b0}}};
          idx_d = '0;
          err_d = 1'b0;
          st_d  = FRPS_SETPGM;
        end
      end
      FRPS_SETPGM: begin
        wr_d    = 1'b1;
        addr_d  = CTRL_ADDR;
        wdata_d = CTRL_PGM;
        st_d    = FRPS_RDPROT;
      end
      FRPS_RDPROT: begin
        rd_d   = 1'b1;
        addr_d = PROT_ADDR;
        st_d   = FRPS_SELROW;
      end
      FRPS_SELROW: begin
        prot_d    = bus_rdata;
        wr_d      = 1'b1;
        addr_d    = row_q;
        wdata_d   = DUMMY_DATA;
        tif.load  = 1'b1;
        tif.count = TMR_W'(NVS_CYC);
        st_d      = FRPS_WNVS;
      end
      FRPS_WNVS: begin
        if (tif.done) begin
          st_d = FRPS_SETHV;
        end
      end
      FRPS_SETHV: begin
        wr_d      = 1'b1;
        addr_d    = CTRL_ADDR;
        wdata_d   = CTRL_PGM_HV;
        tif.load  = 1'b1;
        tif.count = TMR_W'(PGS_CYC);
        st_d      = FRPS_WPGS;
      end
      FRPS_WPGS: begin
        if (tif.done) begin
          st_d = FRPS_CHECK;
        end
      end
      FRPS_CHECK: begin
        // only the address moves: cur_data shows the target byte, and no
        // array read is strobed between program steps
        addr_d = row_q | {10'h000, idx_q};
        st_d   = FRPS_WRBYTE;
      end
      FRPS_WRBYTE: begin
        byte_req = 1'b1;
        last_d   = byte_last || (idx_q == ROW_W'(ROW_BYTES - 1));
        if (cur_data == ERASED_BYTE) begin
          wr_d      = 1'b1;
          wdata_d   = byte_data;
          tif.load  = 1'b1;
          tif.count = TMR_W'(PROG_CYC);
          st_d      = FRPS_WPROG;
        end else begin
          err_d = 1'b1;
          st_d  = FRPS_CLRPGM;
        end
      end
      FRPS_WPROG: begin
        if (tif.done) begin
          idx_d = idx_q + 1'b1;
          st_d  = last_q ? FRPS_CLRPGM : FRPS_CHECK;
        end
      end
      FRPS_CLRPGM: begin
        wr_d      = 1'b1;
        addr_d    = CTRL_ADDR;
        wdata_d   = CTRL_HV;
        tif.load  = 1'b1;
        tif.count = TMR_W'(NVH_CYC);
        st_d      = FRPS_WNVH;
      end
      FRPS_WNVH: begin
        if (tif.done) begin
          st_d = FRPS_CLRHV;
        end
      end
      FRPS_CLRHV: begin
        wr_d      = 1'b1;
        addr_d    = CTRL_ADDR;
        wdata_d   = CTRL_IDLE;
        tif.load  = 1'b1;
        tif.count = TMR_W'(RCV_CYC);
        st_d      = FRPS_WRCV;
      end
      FRPS_WRCV: begin
        if (tif.done) begin
          done_d = 1'b1;
          st_d   = FRPS_IDLE;
        end
      end
      default: st_d = FRPS_IDLE;
    endcase
  end

  // register state and bus outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q           <= FRPS_IDLE;
      idx_q          <= '0;
      row_q          <= '0;
      last_q         <= 1'b0;
      prot_q         <= '0;
      bus_wr         <= 1'b0;
      bus_rd         <= 1'b0;
      bus_addr       <= '0;
      bus_wdata      <= '0;
      done           <= 1'b0;
      err_not_erased <= 1'b0;
    end else begin
      st_q           <= st_d;
      idx_q          <= idx_d;
      row_q          <= row_d;
      last_q         <= last_d;
      prot_q         <= prot_d;
      bus_wr         <= wr_d;
      bus_rd         <= rd_d;
      bus_addr       <= addr_d;
      bus_wdata      <= wdata_d;
      done           <= done_d;
      err_not_erased <= err_d;
    end
  end

  // busy lets the system hold interrupts off while a row is programmed
  assign busy = (st_q != FRPS_IDLE);

  // every array write stays within the selected row
  AST_ROW_BOUND: assert property (
    (bus_wr && bus_addr != CTRL_ADDR) |->
    bus_addr[15:ROW_W] == row_q[15:ROW_W])
    else $error("array write outside row");

  // program mode is set then block protect read next cycle
  AST_PROT_AFTER_PGM: assert property (
    (bus_wr && bus_wdata == CTRL_PGM && st_q == FRPS_RDPROT) |=>
    (bus_rd && bus_addr == PROT_ADDR))
    else $error("no protect read");

  // the protect register is the only location ever read
  AST_NO_ARRAY_READ: assert property (
    bus_rd |-> bus_addr == PROT_ADDR)
    else $error("array read inside sequence");

  sequence s_hv_on;
    st_q == FRPS_SETHV;
  endsequence
  // high voltage only after the setup wait elapsed
  AST_NVS_WAIT: assert property (
    s_hv_on |-> $past(st_q, NVS_CYC) == FRPS_SELROW ||
    $past(st_q, NVS_CYC) == FRPS_WNVS)
    else $error("nvs wait short");

  // byte program wait holds for at least 8 cycles
  AST_PROG_WAIT: assert property (
    (st_q == FRPS_WRBYTE && st_d == FRPS_WPROG) |=>
    (st_q == FRPS_WPROG) [*8])
    else $error("prog wait cut");

  // high voltage cleared only after the whole hold wait
  AST_NVH_ORDER: assert property (
    (st_q == FRPS_CLRHV) |-> $past(st_q) == FRPS_WNVH &&
    $past(st_q, NVH_CYC) == FRPS_WNVH)
    else $error("hv cleared early");

  // a non-erased byte is never written
  AST_ERASED_ONLY: assert property (
    (st_q == FRPS_WRBYTE && cur_data != ERASED_BYTE) |=> !bus_wr)
    else $error("wrote non-erased byte");

  // row select write follows the protect read
  AST_ROW_SELECT: assert property (
    (st_q == FRPS_SELROW) |=> (bus_wr && bus_addr == row_q))
    else $error("row select missing");

  // done appears only after the recovery wait
  AST_RCV_DONE: assert property (
    $rose(done) |-> $past(st_q, 2) == FRPS_WRCV)
    else $error("done before recovery");

  // sequence begins by setting program mode
  AST_PGM_FIRST: assert property (
    (st_q == FRPS_IDLE && start) |=> ##1 (bus_wr && bus_wdata == CTRL_PGM))
    else $error("program mode not first");
endmodule

/* File: common/frps_pkg.sv */
// package of constants and types for the flash row program sequencer
package frps_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned NVS_US         = 10;
  localparam int unsigned PGS_US         = 5;
  localparam int unsigned PROG_US        = 30;
  localparam int unsigned NVH_US         = 5;
  localparam int unsigned RCV_US         = 1;
  // minimum waits round up to whole cycles
  localparam int unsigned NVS_CYC  = (NVS_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int unsigned PGS_CYC  = (PGS_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int unsigned PROG_CYC = (PROG_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int unsigned NVH_CYC  = (NVH_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int unsigned RCV_CYC  = (RCV_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int unsigned TMR_W          = 12;
  localparam int unsigned ROW_BYTES      = 64;
  localparam int unsigned ROW_W          = 6;
  localparam logic [15:0] CTRL_ADDR      = 16'hFF88;
  localparam logic [15:0] PROT_ADDR      = 16'hFF80;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [7:0]  CTRL_IDLE      = 8'h00;
  localparam logic [7:0]  CTRL_PGM       = 8'h01;
  localparam logic [7:0]  CTRL_PGM_HV    = 8'h09;
  localparam logic [7:0]  CTRL_HV        = 8'h08;
  localparam logic [7:0]  DUMMY_DATA     = 8'h00;

  typedef enum logic [3:0] {
    FRPS_IDLE   = 4'b0000,
    FRPS_SETPGM = 4'b0001,
    FRPS_RDPROT = 4'b0011,
    FRPS_SELROW = 4'b0010,
    FRPS_WNVS   = 4'b0110,
    FRPS_SETHV  = 4'b0111,
    FRPS_WPGS   = 4'b0101,
    FRPS_CHECK  = 4'b0100,
    FRPS_WRBYTE = 4'b1100,
    FRPS_WPROG  = 4'b1101,
    FRPS_CLRPGM = 4'b1111,
    FRPS_WNVH   = 4'b1110,
    FRPS_CLRHV  = 4'b1010,
    FRPS_WRCV   = 4'b1011
  } frps_state_e;
endpackage

/* File: common/frps_tmr_if.sv */
// interface between the sequencer and its wait timer
`timescale 1ns/10ps
interface frps_tmr_if;
  import frps_pkg::*;
  logic             load;
  logic [TMR_W-1:0] count;
  logic             done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

/* File: rtl/frps_timer.sv */
// down-counting wait timer for the sequencer
`timescale 1ns/10ps
module frps_timer
  import frps_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  frps_tmr_if.tmr   tif
);
  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  // load on request, count to zero
  always_comb begin
    cnt_d = cnt_q;
    if (tif.load) begin
      cnt_d = tif.count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tif.done = (cnt_q == '0) && !tif.load;
endmodule

/* File: tb/frps_dev_model.sv */
// behavioural flash array and control register seen by the sequencer
`timescale 1ns/10ps
module frps_dev_model
  import frps_pkg::*;
#(
  parameter logic [7:0] PROT_VAL = 8'h00 // arbitrary protect value
)
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  output logic [7:0]       bus_rdata,
  output logic [7:0]       cur_data,
  output int               viol
);
  logic [7:0]  mem [256];
  int unsigned step;
  int unsigned gap;
  int unsigned nb;
  logic [9:0]  row_q;
  logic        ctl;
  logic        arr;
  assign ctl = bus_wr && bus_addr == CTRL_ADDR;
  assign arr = bus_wr && bus_addr[15] && bus_addr < CTRL_ADDR - 16'h0188;
  // reads return the addressed byte, or the protect register
  assign bus_rdata = (bus_addr == PROT_ADDR) ? PROT_VAL : mem[bus_addr[7:0]];
  assign cur_data  = mem[bus_addr[7:0]];
  // step tracker: order, minimum waits and row boundaries
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      foreach (mem[i]) mem[i] <= ERASED_BYTE;
      step <= 0;
      gap  <= 0;
      nb   <= 0;
      viol <= 0;
    end else begin
      gap <= bus_wr ? 1 : gap + 1;
      if (step == 6 && gap >= RCV_CYC) step <= 0;
      if (bus_wr || bus_rd) begin
        case (step)
          0: if (ctl && bus_wdata == CTRL_PGM) step <= 1;
             else if (bus_wr) viol <= viol + 1;
          1: if (bus_rd && bus_addr == PROT_ADDR) step <= 2;
             else viol <= viol + 1;
          2: if (arr) begin
               row_q <= bus_addr[15:6];
               nb    <= 0;
               step  <= 3;
             end else viol <= viol + 1;
          3: if (ctl && bus_wdata == CTRL_PGM_HV && gap >= NVS_CYC)
               step <= 4;
             else viol <= viol + 1;
          4: if (arr) begin
               if (gap < (nb != 0 ? PROG_CYC : PGS_CYC) ||
                   bus_addr[15:6] != row_q ||
                   mem[bus_addr[7:0]] != ERASED_BYTE)
                 viol <= viol + 1;
               mem[bus_addr[7:0]] <= mem[bus_addr[7:0]] & bus_wdata;
               nb <= nb + 1;
             end else if (ctl && bus_wdata == CTRL_HV) begin
               if (nb != 0 && gap < PROG_CYC) viol <= viol + 1;
               step <= 5;
             end else viol <= viol + 1; // array reads count too
          5: if (ctl && bus_wdata == CTRL_IDLE && gap >= NVH_CYC) step <= 6;
             else viol <= viol + 1;
          default: viol <= viol + 1;
        endcase
      end
    end
  end
endmodule

/* File: tb/flash_row_program_sequencer_bench.sv */
// self-checking bench for the flash row program sequencer
`timescale 1ns/10ps
module flash_row_program_sequencer_bench
  import frps_pkg::*;
;
  logic        mclk = 0;
  logic        rst_n = 0;
  logic        start = 0;
  logic        byte_last = 0;
  logic [15:0] row_addr = '0;
  logic [7:0]  byte_data = '0;
  logic        byte_req, busy, done, err_not_erased, bus_wr, bus_rd;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, cur_data;
  logic [7:0]  tbl [64];
  logic        exp_q [$];
  int          viol, idx, n, ndone, failures, tests_run;
  int          seed = 32'h2a9c;
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin \
  failures++; $display("MISMATCH %0t %s", $time, m); end end

  frps_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .start(start),
    .row_addr(row_addr), .byte_req(byte_req), .byte_data(byte_data),
    .byte_last(byte_last), .busy(busy), .done(done),
    .err_not_erased(err_not_erased), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .cur_data(cur_data));
  frps_dev_model dev_u (.mclk(mclk), .rst_n(rst_n), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .cur_data(cur_data), .viol(viol));

  initial forever #5 mclk = ~mclk;
  // hands out the next byte each time one is taken
  always @(posedge mclk) if (byte_req === 1'b1) begin
    idx       <= idx + 1;
    byte_data <= tbl[(idx + 1) % 64];
    byte_last <= (idx + 2 == n);
  end
  // scoreboard: every done takes the oldest expected error flag
  always @(posedge mclk) if (done === 1'b1) begin
    ndone++;
    `CHK(exp_q.size() != 0, 1'b1, "unexpected done")
    if (exp_q.size() != 0) `CHK(err_not_erased, exp_q.pop_front(), "err")
  end
  task automatic wrap_up();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one row program; again pulses start a second time while busy
  task automatic run(logic [15:0] row, int cnt, logic err, logic again);
    int t;
    int d0;
    d0 = ndone;
    @(posedge mclk);
    n = cnt;
    idx       <= 0;
    byte_data <= tbl[0];
    byte_last <= (cnt == 1);
    row_addr  <= row;
    start     <= 1;
    exp_q.push_back(err);
    @(posedge mclk);
    start <= 0;
    @(posedge mclk);
    `CHK(busy, 1'b1, "busy after start")
    if (again) begin
      repeat (20) @(posedge mclk);
      start <= 1;
      @(posedge mclk);
      start <= 0;
    end
    t = 0;
    while (ndone == d0 && t < 20000) begin
      @(posedge mclk);
      t++;
    end
    `CHK(ndone, d0 + 1, "done count")
    `CHK(busy, 1'b0, "idle after done")
    `CHK(idx, err ? 1 : cnt, "byte count")
    repeat (3) @(posedge mclk);
  endtask
  initial begin
    for (int i = 0; i < 64; i++) tbl[i] = $random(seed);
    tbl[0] = tbl[0] & 8'hFE;
    repeat (6) @(posedge mclk);
    rst_n <= 1;
    run(16'h8000 | (16'($random(seed)) & 16'h003F), 3, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++) `CHK(dev_u.mem[i], tbl[i], "byte")
    run(16'h8005, 2, 1'b1, 1'b0);
    run(16'h807F, 2, 1'b0, 1'b0);
    for (int i = 0; i < 2; i++) `CHK(dev_u.mem[64 + i], tbl[i], "row2")
    `CHK(viol, 0, "device sequence")
    wrap_up();
  end
  // watchdog against a hung sequence
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    wrap_up();
  end
endmodule
